// ---- rtl/nmar_top.sv ----
// native max address reporter: apb register file and command logic
// Contract
// - Command code F8h written by the host is recognised as the 28-bit native max query.
// - Command code 27h written by the host is recognised as the 48-bit native max query.
// - The 28-bit query reports the true native maximum, ignoring any reduced limit.
// - A native maximum above 268,435,455 makes the 28-bit query return 268,435,455.
// - In block mode the 28-bit query puts address bits 0-7 in the low address byte.
// - In block mode bits 8-15 go to the mid byte and bits 16-23 to the high byte.
// - In block mode bits 24-27 go to the low four head bits of drive select and head.
// - In cylinder-head-sector mode the 28-bit query returns native cylinder, head, sector.
// - The 48-bit query reports the true 48-bit native maximum, ignoring any reduced limit.
// - With high byte select clear the 48-bit result reads bits 7:0, 15:8, 23:16.
// - With high byte select set the 48-bit result reads bits 31:24, 39:32, 47:40.
`timescale 1ns/1ps
module nmar_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire nmar_pkg::nmar_apb_req_type i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // native geometry of the drive
  input wire nmar_pkg::nmar_native_type i_native,
  // interrupt
  output logic o_irq
);
  // ==================================================================
  // state
  nmar_pkg::nmar_state_type s_q, s_d;
  logic setup, access, wr_acc, mapped, cmd_go;
  logic [27:0] lba28;
  logic [7:0] rd8;
  logic [1:0] ev;

  assign setup = i_apb.psel && !i_apb.penable;
  assign access = i_apb.psel && i_apb.penable && s_q.ready;
  assign wr_acc = access && i_apb.pwrite && !s_q.slverr;
  assign cmd_go = wr_acc && (i_apb.paddr == nmar_pkg::OFS_CMD) && !s_q.busy;
  // clamp: the short form cannot express anything past 28 bits
  assign lba28 = (i_native.lba > {20'h00000, nmar_pkg::LBA28_MAX}) ?
                 nmar_pkg::LBA28_MAX : i_native.lba[27:0];

  // ==================================================================
  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd8 = 8'h00;
    unique case (i_apb.paddr)
      // the host picks upper bytes by setting high byte select
      nmar_pkg::OFS_ADDR_LOW: rd8 = s_q.high_order_byte_select ? s_q.lo_p : s_q.lo;
      nmar_pkg::OFS_ADDR_MID: rd8 = s_q.high_order_byte_select ? s_q.mid_p : s_q.mid;
      nmar_pkg::OFS_ADDR_HIGH: rd8 = s_q.high_order_byte_select ? s_q.hi_p : s_q.hi;
      nmar_pkg::OFS_DRV_HEAD: rd8 = s_q.devhd;
      nmar_pkg::OFS_CMD: rd8 = 8'h00;
      nmar_pkg::OFS_ERROR: rd8 = s_q.err;
      nmar_pkg::OFS_STATUS: rd8 = s_q.stat;
      nmar_pkg::OFS_DEV_CTRL: rd8 = {s_q.high_order_byte_select, 7'h00};
      nmar_pkg::OFS_IRQ_STATUS: rd8 = {6'h00, s_q.ists};
      nmar_pkg::OFS_IRQ_MASK: rd8 = {6'h00, s_q.imsk};
      default: mapped = 1'b0;
    endcase
  end

  // ==================================================================
  // next state
  always_comb begin
    s_d = s_q;
    ev = 2'h0;
    // apb: zero wait states, answer prepared in the setup cycle
    s_d.ready = setup;
    s_d.slverr = setup && !mapped;
    if (setup) begin
      s_d.rdata = {24'h000000, rd8};
    end
    if (wr_acc && !s_q.busy) begin
      unique case (i_apb.paddr)
        nmar_pkg::OFS_ADDR_LOW: begin
          s_d.lo_p = s_q.lo;
          s_d.lo = i_apb.pwdata[7:0];
          s_d.high_order_byte_select = 1'b0;
        end
        nmar_pkg::OFS_ADDR_MID: begin
          s_d.mid_p = s_q.mid;
          s_d.mid = i_apb.pwdata[7:0];
          s_d.high_order_byte_select = 1'b0;
        end
        nmar_pkg::OFS_ADDR_HIGH: begin
          s_d.hi_p = s_q.hi;
          s_d.hi = i_apb.pwdata[7:0];
          s_d.high_order_byte_select = 1'b0;
        end
        nmar_pkg::OFS_DRV_HEAD: begin
          s_d.devhd = i_apb.pwdata[7:0];
          s_d.high_order_byte_select = 1'b0;
        end
        nmar_pkg::OFS_DEV_CTRL: s_d.high_order_byte_select = i_apb.pwdata[nmar_pkg::DEVCTL_HOB];
        nmar_pkg::OFS_CMD: begin
          s_d.cmd = i_apb.pwdata[7:0];
          s_d.busy = 1'b1;
          s_d.high_order_byte_select = 1'b0;
          s_d.stat[nmar_pkg::STAT_BUSY] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (wr_acc && (i_apb.paddr == nmar_pkg::OFS_IRQ_MASK)) begin
      s_d.imsk = i_apb.pwdata[1:0];
    end
    // execution: one cycle of busy, then the result lands
    if (s_q.busy) begin
      s_d.busy = 1'b0;
      s_d.err = 8'h00;
      s_d.stat = nmar_pkg::RST_STATUS;
      ev[nmar_pkg::IRQ_DONE] = 1'b1;
      if (s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX) begin
        if (s_q.devhd[nmar_pkg::DH_LBA_MODE]) begin
          s_d.lo = lba28[7:0];
          s_d.mid = lba28[15:8];
          s_d.hi = lba28[23:16];
          s_d.devhd = {s_q.devhd[7:4], lba28[27:24]};
        end else begin
          s_d.lo = i_native.sect;
          s_d.mid = i_native.cyl[7:0];
          s_d.hi = i_native.cyl[15:8];
          s_d.devhd = {s_q.devhd[7:4], i_native.head};
        end
      end else if (s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX_EXT) begin
        s_d.lo = i_native.lba[7:0];
        s_d.mid = i_native.lba[15:8];
        s_d.hi = i_native.lba[23:16];
        s_d.lo_p = i_native.lba[31:24];
        s_d.mid_p = i_native.lba[39:32];
        s_d.hi_p = i_native.lba[47:40];
      end else begin
        // unknown codes are aborted, address and drive/head registers left untouched
        s_d.err[nmar_pkg::ERR_ABORT] = 1'b1;
        s_d.stat[nmar_pkg::STAT_ERR] = 1'b1;
        ev[nmar_pkg::IRQ_ABORT] = 1'b1;
      end
    end
    // sticky events, write one to clear; a new event beats the clear
    if (wr_acc && (i_apb.paddr == nmar_pkg::OFS_IRQ_STATUS)) begin
      s_d.ists = s_q.ists & ~i_apb.pwdata[1:0];
    end
    s_d.ists = s_d.ists | ev;
    s_d.irq = |(s_d.ists & s_d.imsk);
  end

  // ==================================================================
  // registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q.lo <= nmar_pkg::RST_ZERO8;
      s_q.mid <= nmar_pkg::RST_ZERO8;
      s_q.hi <= nmar_pkg::RST_ZERO8;
      s_q.lo_p <= nmar_pkg::RST_ZERO8;
      s_q.mid_p <= nmar_pkg::RST_ZERO8;
      s_q.hi_p <= nmar_pkg::RST_ZERO8;
      s_q.devhd <= nmar_pkg::RST_DRV_HEAD;
      s_q.cmd <= nmar_pkg::RST_ZERO8;
      s_q.err <= nmar_pkg::RST_ZERO8;
      s_q.stat <= nmar_pkg::RST_STATUS;
      s_q.high_order_byte_select <= 1'b0;
      s_q.busy <= 1'b0;
      s_q.ists <= nmar_pkg::RST_IRQ;
      s_q.imsk <= nmar_pkg::RST_IRQ;
      s_q.rdata <= 32'h00000000;
      s_q.ready <= 1'b0;
      s_q.slverr <= 1'b0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.rdata;
  assign o_pready = s_q.ready;
  assign o_pslverr = s_q.slverr;
  assign o_irq = s_q.irq;

  // ==================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  f8_accept_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX |=> !s_q.err[nmar_pkg::ERR_ABORT])
    else $error("f8 command was aborted");
  ext_accept_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX_EXT
    |=> !s_q.err[nmar_pkg::ERR_ABORT] && !s_q.stat[nmar_pkg::STAT_ERR])
    else $error("27h command was aborted");
  lba28_value_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX && s_q.devhd[nmar_pkg::DH_LBA_MODE]
    && i_native.lba <= 48'h00000fffffff
    |=> {s_q.devhd[3:0], s_q.hi, s_q.mid, s_q.lo} == $past(i_native.lba[27:0]))
    else $error("28-bit result differs from native max");
  lba28_clamp_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX && s_q.devhd[nmar_pkg::DH_LBA_MODE]
    && i_native.lba > 48'h00000fffffff
    |=> {s_q.devhd[3:0], s_q.hi, s_q.mid, s_q.lo} == 28'hfffffff)
    else $error("28-bit result not clamped");
  lba28_bytes_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX && s_q.devhd[nmar_pkg::DH_LBA_MODE]
    |=> s_q.lo == $past(lba28[7:0]) && s_q.mid == $past(lba28[15:8])
    && s_q.hi == $past(lba28[23:16]) && s_q.devhd[3:0] == $past(lba28[27:24]))
    else $error("28-bit bytes misplaced");
  chs_result_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX && !s_q.devhd[nmar_pkg::DH_LBA_MODE]
    |=> s_q.lo == $past(i_native.sect) && {s_q.hi, s_q.mid} == $past(i_native.cyl)
    && s_q.devhd[3:0] == $past(i_native.head))
    else $error("chs result wrong");
  ext_result_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX_EXT
    |=> {s_q.hi_p, s_q.mid_p, s_q.lo_p, s_q.hi, s_q.mid, s_q.lo} == $past(i_native.lba))
    else $error("48-bit result wrong");
  hob_low_read_a: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == nmar_pkg::OFS_ADDR_MID && !s_q.high_order_byte_select
    |=> o_prdata == {24'h000000, $past(s_q.mid)})
    else $error("low byte read wrong");
  hob_high_read_a: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == nmar_pkg::OFS_ADDR_HIGH && s_q.high_order_byte_select
    |=> o_prdata == {24'h000000, $past(s_q.hi_p)})
    else $error("high byte read wrong");
  done_status_a: assert property (
    cmd_go |=> s_q.stat[nmar_pkg::STAT_BUSY] ##1 !s_q.stat[nmar_pkg::STAT_BUSY]
    && !s_q.stat[nmar_pkg::STAT_FAULT] && !s_q.stat[nmar_pkg::STAT_CORR]
    && (s_q.err & ~8'h04) == 8'h00 && s_q.stat[nmar_pkg::STAT_ERR] == s_q.err[nmar_pkg::ERR_ABORT])
    else $error("completion status wrong");

  // ==================================================================
  // bus handshake and interrupt mask write checks
  ready_after_setup_a: assert property (
    setup |=> o_pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (
    o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  unmapped_err_a: assert property (
    setup && (i_apb.paddr[1:0] != 2'h0 || i_apb.paddr > nmar_pkg::OFS_IRQ_MASK)
    |=> o_pslverr && o_pready)
    else $error("unmapped access not flagged");
  mapped_ok_a: assert property (
    setup && i_apb.paddr[1:0] == 2'h0 && i_apb.paddr <= nmar_pkg::OFS_IRQ_MASK
    |=> !o_pslverr)
    else $error("mapped access flagged");
  mask_write_a: assert property (
    wr_acc && i_apb.paddr == nmar_pkg::OFS_IRQ_MASK
    |=> s_q.imsk == $past(i_apb.pwdata[1:0]))
    else $error("mask write lost");

  // ==================================================================
  // command execution checks
  busy_single_a: assert property (
    s_q.busy |=> !s_q.busy && !s_q.stat[nmar_pkg::STAT_BUSY])
    else $error("busy lasted more than one cycle");
  cmd_start_a: assert property (
    cmd_go |=> s_q.busy && !s_q.high_order_byte_select && s_q.cmd == $past(i_apb.pwdata[7:0]))
    else $error("command not started");
  ready_bit_a: assert property (
    s_q.stat[nmar_pkg::STAT_READY])
    else $error("ready status dropped");
  abort_flags_a: assert property (
    s_q.busy && s_q.cmd != nmar_pkg::CMD_READ_NATIVE_MAX
    && s_q.cmd != nmar_pkg::CMD_READ_NATIVE_MAX_EXT
    |=> s_q.err == 8'h04 && s_q.stat == 8'h41 && s_q.ists[nmar_pkg::IRQ_ABORT])
    else $error("unknown code not aborted");
  abort_keeps_a: assert property (
    s_q.busy && s_q.cmd != nmar_pkg::CMD_READ_NATIVE_MAX
    && s_q.cmd != nmar_pkg::CMD_READ_NATIVE_MAX_EXT
    |=> s_q.lo == $past(s_q.lo) && s_q.mid == $past(s_q.mid) && s_q.hi == $past(s_q.hi)
    && s_q.devhd == $past(s_q.devhd))
    else $error("aborted command changed results");
  lba28_upper_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX
    |=> s_q.devhd[7:4] == $past(s_q.devhd[7:4]))
    else $error("drive select bits changed");
  ext_devhd_a: assert property (
    s_q.busy && s_q.cmd == nmar_pkg::CMD_READ_NATIVE_MAX_EXT |=> s_q.devhd == $past(s_q.devhd))
    else $error("48-bit query changed drive select");

  // ==================================================================
  // high byte select and previous-value copies
  shadow_copy_a: assert property (
    wr_acc && !s_q.busy && i_apb.paddr == nmar_pkg::OFS_ADDR_LOW
    |=> s_q.lo_p == $past(s_q.lo) && s_q.lo == $past(i_apb.pwdata[7:0]) && !s_q.high_order_byte_select)
    else $error("address write lost its copy");
  hob_low_sel_a: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == nmar_pkg::OFS_ADDR_LOW && !s_q.high_order_byte_select
    |=> o_prdata == {24'h000000, $past(s_q.lo)})
    else $error("low address byte read wrong");
  hob_high_sel_a: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == nmar_pkg::OFS_ADDR_LOW && s_q.high_order_byte_select
    |=> o_prdata == {24'h000000, $past(s_q.lo_p)})
    else $error("upper address byte read wrong");

  // ==================================================================
  // interrupt checks
  done_event_a: assert property (
    s_q.busy |=> s_q.ists[nmar_pkg::IRQ_DONE])
    else $error("completion event lost");
  irq_level_a: assert property (
    o_irq == |(s_q.ists & s_q.imsk))
    else $error("interrupt level wrong");
  w1c_clear_a: assert property (
    wr_acc && i_apb.paddr == nmar_pkg::OFS_IRQ_STATUS && !s_q.busy
    |=> (s_q.ists & $past(i_apb.pwdata[1:0])) == 2'h0)
    else $error("status bit not cleared");
endmodule // nmar_top

// ---- shared/nmar_pkg.sv ----
// package: constants and carrier types of the native max address reporter
package nmar_pkg;
  // ==================================================================
  // register offsets (byte addresses on apb)
  localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
  localparam logic [7:0] OFS_ADDR_MID = 8'h04;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFS_DRV_HEAD = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_ERROR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_DEV_CTRL = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // ==================================================================
  // command codes
  localparam logic [7:0] CMD_READ_NATIVE_MAX = 8'hf8;
  localparam logic [7:0] CMD_READ_NATIVE_MAX_EXT = 8'h27;
  // ==================================================================
  // field positions
  localparam int STAT_BUSY = 7;
  localparam int STAT_READY = 6;
  localparam int STAT_FAULT = 5;
  localparam int STAT_CORR = 2;
  localparam int STAT_ERR = 0;
  localparam int ERR_ABORT = 2;
  localparam int DH_LBA_MODE = 6;
  localparam int DEVCTL_HOB = 7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  // ==================================================================
  // reset values and limits
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [7:0] RST_DRV_HEAD = 8'ha0;
  localparam logic [7:0] RST_STATUS = 8'h40;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [27:0] LBA28_MAX = 28'hfffffff;
  // ==================================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } nmar_apb_req_type;
  typedef struct packed {
    logic [47:0] lba;
    logic [15:0] cyl;
    logic [3:0] head;
    logic [7:0] sect;
  } nmar_native_type;
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] mid;
    logic [7:0] hi;
    logic [7:0] lo_p;
    logic [7:0] mid_p;
    logic [7:0] hi_p;
    logic [7:0] devhd;
    logic [7:0] cmd;
    logic [7:0] err;
    logic [7:0] stat;
    logic high_order_byte_select;
    logic busy;
    logic [1:0] ists;
    logic [1:0] imsk;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } nmar_state_type;
endpackage

// ---- tb/nmar_host.sv ----
// host-side apb master model that drives the command block registers
`timescale 1ns/1ps
module nmar_host (
  // clock
  input wire logic i_clk,
  // apb master
  output nmar_pkg::nmar_apb_req_type o_apb,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  // ==================================================================
  // bus cycles
  initial begin
    o_apb = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_apb.psel <= 1'b1;
    o_apb.penable <= 1'b0;
    o_apb.pwrite <= w;
    o_apb.paddr <= a;
    o_apb.pwdata <= d;
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_apb.psel <= 1'b0;
    o_apb.penable <= 1'b0;
    // released lines show the inverse so a stale value cannot pass
    o_apb.paddr <= ~a;
    o_apb.pwdata <= ~d;
  endtask
  // hands back the last status seen, so the caller can count a poll that ran out
  task automatic cmd(input logic [7:0] c, output logic [31:0] q);
    logic e;
    int n;
    xfer(1'b1, nmar_pkg::OFS_CMD, {24'h0, c}, q, e);
    n = 0;
    // results are only trusted once busy has dropped
    do begin
      xfer(1'b0, nmar_pkg::OFS_STATUS, 32'h0, q, e);
      n++;
    end while (q[nmar_pkg::STAT_BUSY] !== 1'b0 && n < 16);
  endtask
endmodule // nmar_host

// ---- tb/testbench.sv ----
// self-checking testbench of the native max address reporter
`timescale 1ns/1ps
module testbench;
  logic i_clk;
  logic i_arst_n;
  nmar_pkg::nmar_apb_req_type apb;
  nmar_pkg::nmar_native_type nat;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] q;
  logic er;
  int fail_count = 0;
  int checks = 0;
  nmar_top dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(apb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_native(nat), .o_irq(irq));
  nmar_host host_u (.i_clk(i_clk), .o_apb(apb), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ==================================================================
  // compares and accesses
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.xfer(1'b0, a, 32'h0, q, er);
    chk(q, {24'h0, e});
    chk1(er, 1'b0);
  endtask
  task automatic r3(input logic [23:0] e);
    rchk(nmar_pkg::OFS_ADDR_LOW, e[7:0]);
    rchk(nmar_pkg::OFS_ADDR_MID, e[15:8]);
    rchk(nmar_pkg::OFS_ADDR_HIGH, e[23:16]);
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] st);
    host_u.cmd(c, q);
    chk(q, {24'h0, st});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d}, q, er);
  endtask
  task automatic setn(input logic [47:0] l, input logic [15:0] c, input logic [3:0] h,
                      input logic [7:0] s);
    @(posedge i_clk);
    nat <= '{l, c, h, s};
  endtask
  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==================================================================
  // watchdog, far above the fewer than two hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  // ==================================================================
  // tests
  initial begin
    i_arst_n = 1'b0;
    nat = '0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rchk(nmar_pkg::OFS_STATUS, nmar_pkg::RST_STATUS);
    rchk(nmar_pkg::OFS_DRV_HEAD, nmar_pkg::RST_DRV_HEAD);
    rchk(nmar_pkg::OFS_IRQ_MASK, 8'h00);
    $display("test reset done");
    setn(48'h0000_0765_4321, 16'h1111, 4'h2, 8'h33);
    wr(nmar_pkg::OFS_DRV_HEAD, 8'he0);
    go(nmar_pkg::CMD_READ_NATIVE_MAX, 8'h40);
    r3(24'h654321);
    rchk(nmar_pkg::OFS_DRV_HEAD, 8'he7);
    rchk(nmar_pkg::OFS_STATUS, 8'h40);
    rchk(nmar_pkg::OFS_ERROR, 8'h00);
    $display("test block mode done");
    setn(48'h0000_1000_0000, 16'h0, 4'h0, 8'h0);
    go(nmar_pkg::CMD_READ_NATIVE_MAX, 8'h40);
    r3(24'hffffff);
    rchk(nmar_pkg::OFS_DRV_HEAD, 8'hef);
    setn(48'h1234_5678_9abc, 16'h0, 4'h0, 8'h0);
    go(nmar_pkg::CMD_READ_NATIVE_MAX, 8'h40);
    r3(24'hffffff);
    $display("test clamp done");
    setn(48'h0000_0111_2222, 16'hbeef, 4'h9, 8'h3c);
    wr(nmar_pkg::OFS_DRV_HEAD, 8'ha0);
    go(nmar_pkg::CMD_READ_NATIVE_MAX, 8'h40);
    r3(24'hbeef3c);
    rchk(nmar_pkg::OFS_DRV_HEAD, 8'ha9);
    $display("test geometry mode done");
    setn(48'h1234_5678_9abc, 16'h0, 4'h0, 8'h0);
    go(nmar_pkg::CMD_READ_NATIVE_MAX_EXT, 8'h40);
    r3(24'h789abc);
    wr(nmar_pkg::OFS_DEV_CTRL, 8'h80);
    r3(24'h123456);
    rchk(nmar_pkg::OFS_STATUS, 8'h40);
    wr(nmar_pkg::OFS_ADDR_LOW, 8'h5a);
    rchk(nmar_pkg::OFS_ADDR_LOW, 8'h5a);
    wr(nmar_pkg::OFS_DEV_CTRL, 8'h80);
    rchk(nmar_pkg::OFS_ADDR_LOW, 8'hbc);
    rchk(nmar_pkg::OFS_DEV_CTRL, 8'h80);
    $display("test extended done");
    wr(nmar_pkg::OFS_IRQ_MASK, 8'h02);
    @(negedge i_clk);
    chk1(irq, 1'b0);
    go(8'h55, 8'h41);
    rchk(nmar_pkg::OFS_ERROR, 8'h04);
    rchk(nmar_pkg::OFS_STATUS, 8'h41);
    rchk(nmar_pkg::OFS_IRQ_STATUS, 8'h03);
    chk1(irq, 1'b1);
    wr(nmar_pkg::OFS_IRQ_STATUS, 8'h02);
    @(negedge i_clk);
    chk1(irq, 1'b0);
    rchk(nmar_pkg::OFS_IRQ_STATUS, 8'h01);
    $display("test abort and interrupt done");
    host_u.xfer(1'b0, 8'h30, 32'h0, q, er);
    chk1(er, 1'b1);
    $display("test unmapped done");
    end_sim();
  end
endmodule // testbench
